/* File: core/fdc_param_decode.sv */
// Purpose: Holds and applies floppy command parameters written over APB.
// Assumes: Drive-side strobes (seek_done, sector_done, ID fields) come
//          from logic on pclk.
// Notes:   Every output is registered.
//
// Function
// - With track-count verify, the short-sector count gives sectors to verify.
// - The queue enable bit is active low, 0 enables, 1 disables, 1 at reset.
// - With auto seek set, a seek to the command cylinder precedes read/write if it differs from the present cylinder.
// - The final sector number ends the transfer on the current track.
// - In perpendicular mode the second spacing sets the gap after the ID.
// - The intersector spacing is the gap 3 length between sectors.
// - Head 0 or 1 selects the side and is compared with each sector ID.
// - The head unload delay starts at the end of a read or write execution.
// - Lock decides whether soft reset restores queue and precomp defaults.
// - Density select one means double density, zero single density.
// - Multi-track continues from last sector of head 0 to first of head 1; track-count verify stays on one head.
// - Sector length is 128 times two to the size code, codes up to 7; track-count verify uses 128 bytes for every code.
// - Size code 0 transfers the short-sector byte count instead, except under track-count verify.

`timescale 1ns/1ps

module fdc_param_decode
   import fdc_param_pkg::*;
#(
   parameter int HRD_UNIT = HRD_UNIT_CYCLES
)(
   input  logic              pclk,
   input  logic              presetn,
   input  logic              psel,
   input  logic              penable,
   input  logic              pwrite,
   input  logic [ADDR_W-1:0] paddr,
   input  logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic              pready,
   output logic              pslverr,
   input  logic              seek_done,
   input  logic              sector_done,
   input  logic              id_valid,
   input  logic [7:0]        id_cylinder,
   input  logic              id_head,
   input  logic [7:0]        id_sector,
   output logic              fifo_enable,
   output logic [3:0]        queue_threshold,
   output logic [7:0]        precomp_first_cylinder,
   output logic              double_density_select,
   output logic [7:0]        gap2_length,
   output logic              gap2_override,
   output logic [7:0]        gap3_length,
   output logic              seek_req,
   output logic [7:0]        seek_cylinder,
   output logic              xfer_active,
   output logic              xfer_head,
   output logic [7:0]        xfer_sector,
   output logic [14:0]       xfer_bytes,
   output logic              track_done,
   output logic              head_loaded,
   output logic              id_match,
   output logic              id_mismatch
);

   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------
   function automatic logic [14:0] sector_bytes(input logic [2:0] code,
                                                input logic [7:0] count);
      sector_bytes = (code == SHORT_CODE) ? {7'h00, count}
                     : BASE_SECTOR_LEN << code;
   endfunction

   // ----------------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------------
   config_s     cfg;
   cmd_s        cmd;
   gap_s        gap;
   logic [3:0]  hrd;
   exec_state_e state;
   logic [7:0]  present_cyl;
   logic [7:0]  sector_cur;
   logic [7:0]  sectors_done;
   logic        head_cur;
   logic        verify_cmd;

   // ----------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------
   wire setup    = psel && !penable;
   wire wr_acc   = psel && penable && pready && pwrite;
   wire sel_cfg  = (paddr == CONFIG_OFS);
   wire sel_p0   = (paddr == PARAM0_OFS);
   wire sel_p1   = (paddr == PARAM1_OFS);
   wire sel_tim  = (paddr == TIMING_OFS);
   wire sel_ctl  = (paddr == CONTROL_OFS);
   wire sel_sts  = (paddr == STATUS_OFS);
   wire sel_len  = (paddr == LENGTH_OFS);
   wire mapped   = sel_cfg || sel_p0 || sel_p1 || sel_tim || sel_ctl
                   || sel_sts || sel_len;
   wire ctl_wr   = wr_acc && sel_ctl;
   wire soft_rst = ctl_wr && pwdata[CTL_SRST_BIT];
   wire go_read  = ctl_wr && pwdata[CTL_READ_BIT];
   wire go_write = ctl_wr && pwdata[CTL_WRITE_BIT];
   wire go_vfy   = ctl_wr && pwdata[CTL_VERIFY_BIT];
   wire go_any   = (go_read || go_write || go_vfy) && !soft_rst
                   && (state == ST_IDLE);

   // Transfer sequencing terms.
   wire       vfy_count = verify_cmd && cmd.verify_by_track_count;
   wire       last_id   = vfy_count
                          ? (sectors_done + ONE_SECTOR
                             == gap.short_sector_byte_count)
                          : (sector_cur == cmd.final_sector_number);
   wire       head_wrap = cmd.multi_head_sequencing && !vfy_count
                          && (head_cur == HEAD_ZERO);
   wire       need_seek = cfg.auto_seek_enable
                          && (cmd.cylinder != present_cyl);
   wire       step      = (state == ST_XFER) && sector_done;
   wire       finish    = step && last_id && !head_wrap;
   wire [14:0] bytes_now = vfy_count ? BASE_SECTOR_LEN
                           : sector_bytes(cmd.size_code,
                                          gap.short_sector_byte_count);

   wire [DATA_W-1:0] sts_word = {8'h00, present_cyl, sector_cur, 4'h0,
                                 head_cur, head_loaded,
                                 state == ST_SEEK, state != ST_IDLE};
   wire [DATA_W-1:0] rd_word  =
        sel_cfg ? {15'h0000, cfg}
      : sel_p0  ? cmd
      : sel_p1  ? {7'h00, gap}
      : sel_tim ? {28'h0000000, hrd}
      : sel_sts ? sts_word
      : sel_len ? {17'h00000, bytes_now}
      : {DATA_W{1'b0}};

   // ----------------------------------------------------------------------
   // APB slave, answer in the first access cycle
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= {DATA_W{1'b0}};
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped;
         prdata  <= (setup && !pwrite) ? rd_word : {DATA_W{1'b0}};
      end
   end

   // ----------------------------------------------------------------------
   // Parameter registers
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg                  <= '0;
         cfg.queue_enable_low <= QEN_LOW_RESET;
         cfg.queue_threshold  <= QTHR_RESET;
         cfg.precomp_first_cylinder <= PRECOMP_RESET;
         cmd <= '0;
         gap <= '0;
         hrd <= HRD_RESET;
      end else begin
         if (soft_rst && !cfg.lock) begin
            cfg.queue_enable_low       <= QEN_LOW_RESET;
            cfg.queue_threshold        <= QTHR_RESET;
            cfg.precomp_first_cylinder <= PRECOMP_RESET;
         end else if (wr_acc && sel_cfg) begin
            cfg        <= pwdata[16:0];
            cfg.unused <= 2'b00;
         end
         if (wr_acc && sel_p0) begin
            cmd        <= pwdata;
            cmd.unused <= 1'b0;
         end
         if (wr_acc && sel_p1) begin
            gap <= pwdata[24:0];
         end
         if (wr_acc && sel_tim) begin
            hrd <= pwdata[3:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Execution sequencer
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state        <= ST_IDLE;
         present_cyl  <= 8'h00;
         sector_cur   <= 8'h00;
         sectors_done <= 8'h00;
         head_cur     <= HEAD_ZERO;
         verify_cmd   <= 1'b0;
         track_done   <= 1'b0;
      end else begin
         track_done <= finish;
         if (soft_rst) begin
            state <= ST_IDLE;
         end else begin
            case (state)
               ST_IDLE: begin
                  if (go_any) begin
                     verify_cmd   <= go_vfy;
                     sector_cur   <= cmd.start_sector;
                     sectors_done <= 8'h00;
                     head_cur     <= cmd.head_select;
                     state <= need_seek ? ST_SEEK : ST_XFER;
                  end
               end
               ST_SEEK: begin
                  if (seek_done) begin
                     present_cyl <= cmd.cylinder;
                     state       <= ST_XFER;
                  end
               end
               ST_XFER: begin
                  if (step) begin
                     sectors_done <= sectors_done + ONE_SECTOR;
                     if (last_id && head_wrap) begin
                        head_cur   <= HEAD_ONE;
                        sector_cur <= FIRST_SECTOR_H1;
                     end else if (last_id) begin
                        state <= ST_IDLE;
                     end else begin
                        sector_cur <= sector_cur + ONE_SECTOR;
                     end
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Registered drive-side outputs
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_enable            <= 1'b0;
         queue_threshold        <= QTHR_RESET;
         precomp_first_cylinder <= PRECOMP_RESET;
         double_density_select  <= 1'b0;
         gap2_length            <= 8'h00;
         gap2_override          <= 1'b0;
         gap3_length            <= 8'h00;
         seek_req               <= 1'b0;
         seek_cylinder          <= 8'h00;
         xfer_active            <= 1'b0;
         xfer_head              <= HEAD_ZERO;
         xfer_sector            <= 8'h00;
         xfer_bytes             <= 15'h0000;
      end else begin
         fifo_enable            <= !cfg.queue_enable_low;
         queue_threshold        <= cfg.queue_threshold;
         precomp_first_cylinder <= cfg.precomp_first_cylinder;
         double_density_select  <= cmd.double_density_select;
         gap2_override          <= gap.perpendicular;
         gap2_length            <= gap.gap2_length;
         gap3_length            <= gap.intersector_spacing_length;
         seek_req               <= (state == ST_SEEK) && !seek_done;
         seek_cylinder          <= cmd.cylinder;
         xfer_active            <= (state == ST_XFER);
         xfer_head              <= head_cur;
         xfer_sector            <= sector_cur;
         xfer_bytes             <= bytes_now;
      end
   end

   // ----------------------------------------------------------------------
   // Head unload timing and ID comparison
   // ----------------------------------------------------------------------
   wire hrd_expired;

   head_release_timer #(
      .UNIT_CYCLES (HRD_UNIT)
   ) u_head_release_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (finish),
      .cancel  (go_any || soft_rst),
      .units   (hrd),
      .running (),
      .expired (hrd_expired)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         head_loaded <= 1'b0;
      end else if (go_any) begin
         head_loaded <= 1'b1;
      end else if (hrd_expired || soft_rst) begin
         head_loaded <= 1'b0;
      end
   end

   sector_id_matcher u_sector_id_matcher (
      .pclk         (pclk),
      .presetn      (presetn),
      .enable       (state == ST_XFER),
      .id_valid     (id_valid),
      .id_cylinder  (id_cylinder),
      .id_head      (id_head),
      .id_sector    (id_sector),
      .exp_cylinder (cmd.cylinder),
      .exp_head     (head_cur),
      .exp_sector   (sector_cur),
      .match        (id_match),
      .mismatch     (id_mismatch)
   );

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   sequence s_start_seek;
      go_any && need_seek;
   endsequence

   sequence s_seek_to_xfer;
      (state == ST_SEEK) ##1 (state == ST_XFER);
   endsequence

   a_fifo_polarity: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 fifo_enable == !$past(cfg.queue_enable_low))
      else $error("fifo enable polarity wrong");

   a_soft_reset_lock: assert property (@(posedge pclk) disable iff (!presetn)
      soft_rst && !cfg.lock |=> cfg.queue_enable_low
                                && cfg.queue_threshold == QTHR_RESET)
      else $error("soft reset did not restore defaults");

   a_locked_keep: assert property (@(posedge pclk) disable iff (!presetn)
      soft_rst && cfg.lock |=> $stable(cfg))
      else $error("locked configuration changed on soft reset");

   a_implied_seek: assert property (@(posedge pclk) disable iff (!presetn)
      s_start_seek |=> (state == ST_SEEK) ##1 seek_req)
      else $error("implied seek not performed");

   a_seek_completes: assert property (@(posedge pclk) disable iff (!presetn)
      (state == ST_SEEK) && seek_done && !soft_rst |-> s_seek_to_xfer)
      else $error("seek completion did not start transfer");

   a_no_seek: assert property (@(posedge pclk) disable iff (!presetn)
      go_any && !cfg.auto_seek_enable |=> state == ST_XFER)
      else $error("seek issued with auto seek off");

   a_track_end: assert property (@(posedge pclk) disable iff (!presetn)
      finish && !soft_rst |=> state == ST_IDLE && track_done)
      else $error("transfer did not end at final sector");

   a_mt_switch: assert property (@(posedge pclk) disable iff (!presetn)
      step && last_id && head_wrap && !soft_rst
      |=> head_cur == HEAD_ONE && sector_cur == FIRST_SECTOR_H1)
      else $error("multi-track did not move to head one");

   a_short_bytes: assert property (@(posedge pclk) disable iff (!presetn)
      !vfy_count && cmd.size_code == SHORT_CODE
      |=> xfer_bytes == {7'h00, $past(gap.short_sector_byte_count)})
      else $error("short sector byte count not applied");

   a_density_out: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(cmd.double_density_select) |=> double_density_select)
      else $error("density select not applied");

endmodule // fdc_param_decode

/* File: core/fdc_param_pkg.sv */
// Purpose: Shared constants and carriers for the command parameter decoder.
// Assumes: APB with 32-bit data, byte addresses, one register per word.
// Notes:   Field layouts of the register words are the packed structs below.

package fdc_param_pkg;

   // ----------------------------------------------------------------------
   // Bus and register map
   // ----------------------------------------------------------------------
   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 32;
   localparam logic [7:0]  CONFIG_OFS  = 8'h00;
   localparam logic [7:0]  PARAM0_OFS  = 8'h04;
   localparam logic [7:0]  PARAM1_OFS  = 8'h08;
   localparam logic [7:0]  TIMING_OFS  = 8'h0C;
   localparam logic [7:0]  CONTROL_OFS = 8'h10;
   localparam logic [7:0]  STATUS_OFS  = 8'h14;
   localparam logic [7:0]  LENGTH_OFS  = 8'h18;

   // Control register command bits, write-only pulses.
   localparam int CTL_READ_BIT   = 0;
   localparam int CTL_WRITE_BIT  = 1;
   localparam int CTL_VERIFY_BIT = 2;
   localparam int CTL_SRST_BIT   = 3;

   // ----------------------------------------------------------------------
   // Reset values and sector arithmetic
   // ----------------------------------------------------------------------
   localparam logic        QEN_LOW_RESET   = 1'b1;
   localparam logic [3:0]  QTHR_RESET      = 4'h0;
   localparam logic [7:0]  PRECOMP_RESET   = 8'h00;
   localparam logic [3:0]  HRD_RESET       = 4'h0;
   localparam logic [14:0] BASE_SECTOR_LEN = 15'h0080;
   localparam logic [2:0]  SHORT_CODE      = 3'h0;
   localparam logic [7:0]  FIRST_SECTOR_H1 = 8'h01;
   localparam logic [7:0]  ONE_SECTOR      = 8'h01;
   localparam logic        HEAD_ZERO       = 1'b0;
   localparam logic        HEAD_ONE        = 1'b1;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 5;
   localparam int HRD_UNIT_NS     = 16000000;
   localparam int HRD_UNIT_CYCLES = HRD_UNIT_NS / CLK_PERIOD_NS;
   localparam logic [4:0] HRD_ZERO_UNITS = 5'h10;

   // ----------------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic       lock;
      logic [7:0] precomp_first_cylinder;
      logic [3:0] queue_threshold;
      logic [1:0] unused;
      logic       auto_seek_enable;
      logic       queue_enable_low;
   } config_s;

   typedef struct packed {
      logic [7:0] final_sector_number;
      logic [7:0] start_sector;
      logic [7:0] cylinder;
      logic       unused;
      logic [2:0] size_code;
      logic       verify_by_track_count;
      logic       head_select;
      logic       double_density_select;
      logic       multi_head_sequencing;
   } cmd_s;

   typedef struct packed {
      logic       perpendicular;
      logic [7:0] gap2_length;
      logic [7:0] intersector_spacing_length;
      logic [7:0] short_sector_byte_count;
   } gap_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SEEK = 3'b010,
      ST_XFER = 3'b100
   } exec_state_e;

endpackage

/* File: core/head_release_timer.sv */
// Purpose: Counts the head unload interval after a transfer ends.
// Assumes: Start and cancel are single-cycle pulses on pclk.
// Notes:   A programmed value of zero stands for sixteen units.

`timescale 1ns/1ps

module head_release_timer
   import fdc_param_pkg::*;
#(
   parameter int UNIT_CYCLES = HRD_UNIT_CYCLES
)(
   input  logic       pclk,
   input  logic       presetn,
   input  logic       start,
   input  logic       cancel,
   input  logic [3:0] units,
   output logic       running,
   output logic       expired
);

   logic [31:0] tick;
   logic [4:0]  left;
   wire         unit_end = (tick == 32'(UNIT_CYCLES - 1));
   wire  [4:0]  load     = (units == 4'h0) ? HRD_ZERO_UNITS : {1'b0, units};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick    <= 32'h0000_0000;
         left    <= 5'h00;
         running <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= running && unit_end && (left == 5'h01) && !cancel;
         if (cancel || start) begin
            tick    <= 32'h0000_0000;
            left    <= load;
            running <= start && !cancel;
         end else if (running) begin
            tick <= unit_end ? 32'h0000_0000 : tick + 32'h0000_0001;
            if (unit_end) begin
               left    <= left - 5'h01;
               running <= (left != 5'h01);
            end
         end
      end
   end

   a_unload_start: assert property (@(posedge pclk) disable iff (!presetn)
      start && !cancel |=> running && !expired)
      else $error("unload timer did not start");

   a_unload_end: assert property (@(posedge pclk) disable iff (!presetn)
      expired |-> $past(running) && !running)
      else $error("unload expiry without running timer");

endmodule // head_release_timer

/* File: core/sector_id_matcher.sv */
// Purpose: Compares each sector ID read from the disk with the expected one.
// Assumes: ID fields arrive from the data separator on pclk with a valid.
// Notes:   Results are single-cycle pulses one edge after the ID.

`timescale 1ns/1ps

module sector_id_matcher (
   input  logic       pclk,
   input  logic       presetn,
   input  logic       enable,
   input  logic       id_valid,
   input  logic [7:0] id_cylinder,
   input  logic       id_head,
   input  logic [7:0] id_sector,
   input  logic [7:0] exp_cylinder,
   input  logic       exp_head,
   input  logic [7:0] exp_sector,
   output logic       match,
   output logic       mismatch
);

   wire same = (id_cylinder == exp_cylinder) && (id_head == exp_head)
               && (id_sector == exp_sector);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match    <= 1'b0;
         mismatch <= 1'b0;
      end else begin
         match    <= enable && id_valid && same;
         mismatch <= enable && id_valid && !same;
      end
   end

   a_head_compare: assert property (@(posedge pclk) disable iff (!presetn)
      enable && id_valid && (id_head != exp_head) |=> mismatch && !match)
      else $error("head mismatch not flagged");

endmodule // sector_id_matcher

/* File: verif/drive_model.sv */
// Purpose: Drive side model that answers seeks and streams sector IDs.
// Assumes: Design strobes and levels are on pclk.
// Notes:   IDs carry the cylinder that the drive last sought to.

`timescale 1ns/1ps

module drive_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       seek_req,
   input  wire logic [7:0] seek_cylinder,
   input  wire logic       xfer_active,
   input  wire logic       xfer_head,
   input  wire logic [7:0] xfer_sector,
   output logic            seek_done,
   output logic            sector_done,
   output logic            id_valid,
   output logic [7:0]      id_cylinder,
   output logic            id_head,
   output logic [7:0]      id_sector
);
   logic [7:0] cyl;
   logic [2:0] cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 3'h0;
         cyl <= 8'h00;
      end else begin
         cnt <= (seek_req | xfer_active) ? cnt + 3'h1 : 3'h0;
         if (seek_done) cyl <= seek_cylinder;
      end
   end
   assign seek_done   = seek_req & (cnt == 3'h7);
   assign sector_done = xfer_active & (cnt == 3'h7);
   assign id_valid    = xfer_active & (cnt == 3'h3);
   // Idle ID lines show the inverse so a stale value never matches.
   assign id_cylinder = id_valid ? cyl : ~cyl;
   assign id_head     = xfer_head ^ ~id_valid;
   assign id_sector   = id_valid ? xfer_sector : ~xfer_sector;
endmodule // drive_model

/* File: verif/floppy_command_parameter_decode_test.sv */
// Purpose: Self-checking bench for the command parameter decoder.
// Assumes: APB master here, drive model on the far side.
// Notes:   Head unload unit shortened to four cycles.

`timescale 1ns/1ps

module floppy_command_parameter_decode_test;
   import fdc_param_pkg::*;
   localparam int U = 4;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        seek_done, sector_done, id_valid, id_head, fifo_enable;
   logic        double_density_select, gap2_override, seek_req, xfer_head;
   logic        xfer_active, track_done, head_loaded, id_match, id_mismatch;
   logic [3:0]  queue_threshold;
   logic [7:0]  paddr, id_cylinder, id_sector, precomp_first_cylinder;
   logic [7:0]  gap2_length, gap3_length, seek_cylinder, xfer_sector;
   logic [14:0] xfer_bytes;
   logic [31:0] pwdata, prdata, r, rnd;
   logic [8:0]  q[$];
   int          failures, num_checks, seed, seeks, hits, misses;
   fdc_param_decode #(.HRD_UNIT(U)) fdc_param_decode_inst (.*);
   drive_model drive_model_inst (.*);
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic cmd(input logic [31:0] p0, input int c, input logic [11:0] e);
      wr(PARAM0_OFS, p0);
      seeks = 0;
      hits = 0;
      misses = 0;
      wr(CONTROL_OFS, 32'h1 << c);
      while (track_done !== 1'b1) @(posedge pclk);
      chk(q.size(), 0);
      chk(seeks << 8 | hits << 4 | misses, e);
      if (c != CTL_VERIFY_BIT) begin
         repeat (2 * U - 2) @(posedge pclk);
         chk(head_loaded, 1);
         repeat (4) @(posedge pclk);
         chk(head_loaded, 0);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(r, e);
   endtask
   task automatic test_done;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge pclk) begin
      if (seek_done) seeks++;
      if (id_match) hits++;
      if (id_mismatch) misses++;
      if (sector_done && xfer_active)
         chk({xfer_head, xfer_sector}, q.size() ? q.pop_front() : 9'h1FF);
   end
   initial begin
      #50us;
      failures++;
      test_done;
   end
   initial begin
      {seed, failures, num_checks} = {32'd83295, 64'd0};
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(fifo_enable, 0);
      rd(CONFIG_OFS, 32'h1);
      apb(1'b0, 8'h1C, 32'h0);
      chk(err, 1);
      wr(CONFIG_OFS, 32'h750);
      @(posedge pclk);
      chk(fifo_enable, 1);
      wr(CONTROL_OFS, 32'h8);
      rd(CONFIG_OFS, 32'h1);
      wr(CONFIG_OFS, 32'h10750);
      wr(CONTROL_OFS, 32'h8);
      rd(CONFIG_OFS, 32'h10750);
      chk({fifo_enable, queue_threshold, precomp_first_cylinder}, 13'h1507);
      $display("config test done");
      // Only codes 0 to 7 are sent, all within what a drive can hold.
      for (int c = 0; c < 8; c++) begin
         rnd = $random(seed);
         wr(PARAM1_OFS, rnd);
         wr(PARAM0_OFS, {25'h0, c[2:0], 2'h0, c[0], 1'b0});
         rd(LENGTH_OFS, c ? 32'h80 << c : rnd[7:0]);
         chk(xfer_bytes, c ? 32'h80 << c : rnd[7:0]);
         chk({gap2_override, gap2_length, gap3_length}, rnd[24:8]);
         chk(double_density_select, c[0]);
      end
      $display("size test done");
      wr(CONFIG_OFS, 32'h2);
      wr(TIMING_OFS, 32'h2);
      wr(PARAM1_OFS, 32'h3);
      for (int i = 0; i < 4; i++) q.push_back({i[1], 6'h0, i[0], ~i[0]});
      cmd(32'h02010501, CTL_READ_BIT, 12'h140);
      for (int i = 1; i < 4; i++) q.push_back(9'(i));
      cmd(32'h01010509, CTL_VERIFY_BIT, 12'h030);
      wr(CONFIG_OFS, 32'h0);
      q.push_back(9'h104);
      cmd(32'h04040904, CTL_WRITE_BIT, 12'h001);
      rd(STATUS_OFS, 32'h00050408);
      $display("command test done");
      test_done;
   end
endmodule // floppy_command_parameter_decode_test
